// ===== logic/rafd_pkg.sv
// constants and types shared by the addressing format decoder
package rafd_pkg;
	localparam int unsigned XLEN       = 32;
	localparam int unsigned ILEN       = 16;
	localparam logic [31:0] PC_STEP    = 32'h0000_0002;
	localparam logic [31:0] SZ_BYTE    = 32'h0000_0001;
	localparam logic [31:0] SZ_WORD    = 32'h0000_0002;
	localparam logic [31:0] SZ_LONG    = 32'h0000_0004;
	localparam logic [3:0]  REG_ZERO   = 4'h0;
	localparam logic [7:0]  TAS_MSB    = 8'h80;
	localparam int unsigned VEC_SHIFT  = 2;
	localparam int unsigned WAIT_W     = 4;

	typedef enum logic [1:0] {
		RAFD_SZ_B = 2'h0,
		RAFD_SZ_W = 2'h1,
		RAFD_SZ_L = 2'h2
	} rafd_size_t;

	// operand addressing modes
	typedef enum logic [3:0] {
		RAFD_AM_NONE  = 4'h0,
		RAFD_AM_REG   = 4'h1,
		RAFD_AM_IND   = 4'h2,
		RAFD_AM_POST  = 4'h3,
		RAFD_AM_PRE   = 4'h4,
		RAFD_AM_DISP  = 4'h5,
		RAFD_AM_IDX   = 4'h6,
		RAFD_AM_GBR   = 4'h7,
		RAFD_AM_PCD   = 4'h8,
		RAFD_AM_PCR   = 4'h9,
		RAFD_AM_IMM   = 4'hA
	} rafd_mode_t;

	// functional classes
	typedef enum logic [3:0] {
		RAFD_OP_OTHER = 4'h0,
		RAFD_OP_BF    = 4'h1,
		RAFD_OP_BT    = 4'h2,
		RAFD_OP_BRA   = 4'h3,
		RAFD_OP_TAS   = 4'h4,
		RAFD_OP_TST   = 4'h5,
		RAFD_OP_XTR   = 4'h6,
		RAFD_OP_DIVS  = 4'h7,
		RAFD_OP_ROTATE_LEFT_THROUGH_T = 4'h8,
		RAFD_OP_MAC   = 4'h9,
		RAFD_OP_TRAP  = 4'hA,
		RAFD_OP_ILL   = 4'hB
	} rafd_op_t;

	// decode pipe states, gray along idle-issue-hold
	typedef enum logic [1:0] {
		RAFD_ST_IDLE  = 2'b00,
		RAFD_ST_ISSUE = 2'b01,
		RAFD_ST_HOLD  = 2'b11
	} rafd_state_t;
endpackage

// ===== logic/rafd_ext.sv
// immediate extension and displacement scaling unit
`timescale 1ns/10ps
`default_nettype none
module rafd_ext
	import rafd_pkg::*;
(
	input  wire logic [7:0]  imm8,
	input  wire logic        imm_signed,
	input  wire logic        imm_trap,
	input  wire logic [11:0] disp,
	input  wire logic [3:0]  disp_bits,
	input  wire rafd_size_t  size,
	output logic      [31:0] imm_ext,
	output logic      [31:0] disp_ext
);
	logic [31:0] d_raw;

	always_comb
	begin
		if (imm_trap)
			imm_ext = {22'h000000, imm8, 2'h0}; // RULE_07
		else if (imm_signed)
			imm_ext = {{24{imm8[7]}}, imm8}; // RULE_06
		else
			imm_ext = {24'h000000, imm8}; // RULE_05
	end

	// 4-bit disp is unsigned, 8-bit unsigned except branches, 12-bit signed
	always_comb
	begin
		case (disp_bits)
			4'h4:    d_raw = {28'h0000000, disp[3:0]};
			4'h8:    d_raw = {24'h000000, disp[7:0]};
			4'h9:    d_raw = {{24{disp[7]}}, disp[7:0]};
			default: d_raw = {{20{disp[11]}}, disp[11:0]};
		endcase
		case (size)
			RAFD_SZ_W: disp_ext = {d_raw[30:0], 1'b0}; // RULE_15
			RAFD_SZ_L: disp_ext = {d_raw[29:0], 2'h0}; // RULE_15
			default:   disp_ext = d_raw;
		endcase
	end
endmodule
`default_nettype wire

// ===== logic/rafd_decoder.sv
// instruction format and effective address decoder
// Behaviour
// RULE_01: direct register operand; indirect uses register contents
// RULE_02: post-increment uses original, adds 1/2/4
// RULE_03: pre-decrement subtracts 1/2/4, uses result
// RULE_04: register PC-relative target is PC plus register
// RULE_05: logical immediates zero-extended to 32 bits
// RULE_06: copy/add/compare immediates sign-extended
// RULE_07: trap immediate zero-extended then times four
// RULE_08: multiply-accumulate dest_field is second post-increment source
// RULE_09: md layout: source, displacement, result register_zero
// RULE_10: nd4 layout: base, displacement, register_zero stores
// RULE_11: nmd layout: dest, source, displacement fields
// RULE_12: d layout: 8-bit disp, GLOBAL_BASE_REGISTER/PC or branch
// RULE_13: nd8 layout: destination, PC-relative load displacement
// RULE_14: ni layout: destination and 8-bit immediate
// RULE_15: displacement scaled by operand size
// RULE_16: false branch on flag 0, true on 1
// RULE_17: test-and-set: flag if zero, set msb
// RULE_18: and-test sets flag when product zero
// RULE_19: middle_extract takes middle 32 of 64 bits
// RULE_20: divide init loads sign bits, flag xor
// RULE_21: rotate left through flag
// RULE_22: wait states stretch execution counts
// RULE_23: fetch and decode advance in 16-bit units
// RULE_24: delay slot executes before branch transfer
// RULE_25: d12 layout: 12-bit PC-relative branch
// RULE_26: undefined opcodes flagged as illegal
`timescale 1ns/10ps
`default_nettype none
module rafd_decoder
	import rafd_pkg::*;
(
	input  wire logic        core_clk,
	input  wire logic        nrst,
	input  wire logic        insn_valid,
	input  wire logic [15:0] insn_word,
	input  wire logic [31:0] pc_value,
	input  wire logic [31:0] gbr_value,
	input  wire logic [31:0] src_value,
	input  wire logic [31:0] dst_value,
	input  wire logic [31:0] r0_value,
	input  wire logic        cond_flag,
	input  wire logic [7:0]  mem_byte,
	input  wire logic        bus_wait,
	output logic             insn_ready,
	output logic             dec_valid_q,
	output rafd_mode_t       src_mode_q,
	output rafd_mode_t       dst_mode_q,
	output rafd_op_t         op_class_q,
	output rafd_size_t       size_q,
	output logic      [3:0]  src_reg_q,
	output logic      [3:0]  dst_reg_q,
	output logic      [31:0] imm_q,
	output logic      [31:0] ea_q,
	output logic             wb_en_q,
	output logic      [3:0]  wb_reg_q,
	output logic      [31:0] wb_val_q,
	output logic             wb2_en_q,
	output logic      [3:0]  wb2_reg_q,
	output logic      [31:0] wb2_val_q,
	output logic             mem_access_q,
	output logic             branch_q,
	output logic             delay_slot_q,
	output logic      [31:0] target_q,
	output logic             flag_we_q,
	output logic             flag_val_q,
	output logic      [31:0] alu_res_q,
	output logic             qbit_q,
	output logic             mbit_q,
	output logic      [7:0]  tas_byte_q,
	output logic             illegal_q,
	output logic      [31:0] fetch_pc_q
);
	rafd_state_t state_q;
	logic [3:0]  f_hi, f_n, f_m, f_lo;
	logic [7:0]  f_op8;
	rafd_mode_t  sm_d, dm_d;
	rafd_op_t    op_d;
	rafd_size_t  sz_d;
	logic        isgn_d, itrap_d, ill_d, dslot_d;
	logic [3:0]  dbits_d;
	logic [11:0] disp_d;
	logic [31:0] imm_ext, disp_ext, step, step_q;
	logic        take;

	assign f_hi  = insn_word[15:12];
	assign f_n   = insn_word[11:8];  // RULE_11
	assign f_m   = insn_word[7:4];
	assign f_lo  = insn_word[3:0];
	assign f_op8 = insn_word[15:8];
	assign take  = insn_valid && insn_ready;

	rafd_ext u_ext (
		.imm8       (insn_word[7:0]),
		.imm_signed (isgn_d),
		.imm_trap   (itrap_d),
		.disp       (disp_d),
		.disp_bits  (dbits_d),
		.size       (sz_d),
		.imm_ext    (imm_ext),
		.disp_ext   (disp_ext)
	);

	////////////////////////////////////////////////////////////////////////
	// format decode
	always_comb
	begin
		sm_d    = RAFD_AM_NONE;
		dm_d    = RAFD_AM_NONE;
		op_d    = RAFD_OP_OTHER;
		sz_d    = rafd_size_t'(insn_word[1:0]);
		isgn_d  = 1'b0;
		itrap_d = 1'b0;
		ill_d   = 1'b0;
		dslot_d = 1'b0;
		dbits_d = 4'h4;
		disp_d  = {8'h00, f_lo};
		case (f_hi)
			4'h0:
			begin
				if (f_lo == 4'hF)
				begin
					op_d = RAFD_OP_MAC; // RULE_08
					sm_d = RAFD_AM_POST;
					dm_d = RAFD_AM_POST;
					sz_d = RAFD_SZ_L;
				end
				else if (f_lo[3:2] == 2'h1 || f_lo[3:2] == 2'h3)
				begin
					sm_d = f_lo[3] ? RAFD_AM_IDX : RAFD_AM_REG;
					dm_d = f_lo[3] ? RAFD_AM_REG : RAFD_AM_IDX;
					ill_d = (f_lo[1:0] == 2'h3);
				end
				else
					sm_d = RAFD_AM_NONE;
			end
			4'h1:
			begin
				sm_d = RAFD_AM_REG; // RULE_11
				dm_d = RAFD_AM_DISP;
				sz_d = RAFD_SZ_L;
			end
			4'h2:
			begin
				sm_d = RAFD_AM_REG;
				case (f_lo)
					4'h0, 4'h1, 4'h2: dm_d = RAFD_AM_IND; // RULE_01
					4'h4, 4'h5, 4'h6: dm_d = RAFD_AM_PRE; // RULE_03
					4'h7:             op_d = RAFD_OP_DIVS;
					4'h8:             op_d = RAFD_OP_TST;
					4'hD:             op_d = RAFD_OP_XTR;
					4'h3:             ill_d = 1'b1; // RULE_26
					default:          dm_d = RAFD_AM_REG;
				endcase
				if (f_lo[3] || f_lo == 4'h7)
					dm_d = RAFD_AM_REG;
			end
			4'h3:
			begin
				sm_d = RAFD_AM_REG;
				dm_d = RAFD_AM_REG;
				ill_d = (f_lo == 4'h1) || (f_lo == 4'h9);
			end
			4'h4:
			begin
				if (f_lo == 4'hF)
				begin
					op_d = RAFD_OP_MAC;
					sm_d = RAFD_AM_POST;
					dm_d = RAFD_AM_POST;
					sz_d = RAFD_SZ_W;
				end
				else if (f_m == 4'h1 && f_lo == 4'hB)
				begin
					op_d = RAFD_OP_TAS;
					dm_d = RAFD_AM_IND;
					sz_d = RAFD_SZ_B;
				end
				else if (f_m == 4'h2 && f_lo == 4'h4)
				begin
					op_d = RAFD_OP_ROTATE_LEFT_THROUGH_T;
					dm_d = RAFD_AM_REG;
				end
				else if (f_m == 4'h2 && f_lo == 4'h3)
				begin
					op_d = RAFD_OP_BRA; // RULE_04
					sm_d = RAFD_AM_PCR;
					dslot_d = 1'b1;
				end
				else
					dm_d = RAFD_AM_REG;
			end
			4'h5:
			begin
				sm_d = RAFD_AM_DISP; // RULE_11
				dm_d = RAFD_AM_REG;
				sz_d = RAFD_SZ_L;
			end
			4'h6:
			begin
				dm_d = RAFD_AM_REG;
				// register copy and bit-invert sit inside the memory-form nibble groups
				if (f_lo == 4'h3 || f_lo == 4'h7)
					sm_d = RAFD_AM_REG; // RULE_01
				else if (f_lo[3:2] == 2'h0)
					sm_d = RAFD_AM_IND;
				else if (f_lo[3:2] == 2'h1)
					sm_d = RAFD_AM_POST; // RULE_02
				else
					sm_d = RAFD_AM_REG;
			end
			4'h7, 4'hE:
			begin
				sm_d   = RAFD_AM_IMM; // RULE_14
				dm_d   = RAFD_AM_REG;
				isgn_d = 1'b1;
			end
			4'h8:
			begin
				dbits_d = 4'h4;
				sz_d    = rafd_size_t'(f_op8[1:0]);
				case (f_n)
					4'h0, 4'h1: dm_d = RAFD_AM_DISP; // RULE_10
					4'h4, 4'h5: sm_d = RAFD_AM_DISP; // RULE_09
					4'h8:
					begin
						sm_d   = RAFD_AM_IMM;
						isgn_d = 1'b1;
					end
					4'h9, 4'hB, 4'hD, 4'hF:
					begin
						op_d    = f_n[1] ? RAFD_OP_BF : RAFD_OP_BT; // RULE_16
						if (f_n == 4'hB || f_n == 4'h9)
							op_d = (f_n == 4'h9) ? RAFD_OP_BT : RAFD_OP_BF;
						else
							op_d = (f_n == 4'hD) ? RAFD_OP_BT : RAFD_OP_BF;
						dslot_d = f_n[2];
						dbits_d = 4'h9;
						sz_d    = RAFD_SZ_W;
						disp_d  = {4'h0, insn_word[7:0]};
						sm_d    = RAFD_AM_PCD;
					end
					default: ill_d = 1'b1;
				endcase
			end
			4'h9, 4'hD:
			begin
				sm_d    = RAFD_AM_PCD; // RULE_13
				dm_d    = RAFD_AM_REG;
				dbits_d = 4'h8;
				disp_d  = {4'h0, insn_word[7:0]};
				sz_d    = f_hi[2] ? RAFD_SZ_L : RAFD_SZ_W;
			end
			4'hA, 4'hB:
			begin
				op_d    = RAFD_OP_BRA; // RULE_25
				sm_d    = RAFD_AM_PCD;
				dbits_d = 4'hC;
				disp_d  = insn_word[11:0];
				sz_d    = RAFD_SZ_W;
				dslot_d = 1'b1;
			end
			4'hC:
			begin
				dbits_d = 4'h8; // RULE_12
				disp_d  = {4'h0, insn_word[7:0]};
				sz_d    = rafd_size_t'(f_n[1:0]);
				if (f_n == 4'h3)
				begin
					op_d    = RAFD_OP_TRAP;
					sm_d    = RAFD_AM_IMM;
					itrap_d = 1'b1;
				end
				else if (f_n == 4'h7)
				begin
					sm_d = RAFD_AM_PCD;
					sz_d = RAFD_SZ_L;
				end
				else if (f_n[3])
				begin
					sm_d = RAFD_AM_IMM;
					op_d = (f_n[1:0] == 2'h0) ? RAFD_OP_TST : RAFD_OP_OTHER;
					dm_d = f_n[2] ? RAFD_AM_GBR : RAFD_AM_REG;
				end
				else if (f_n[2])
					sm_d = RAFD_AM_GBR;
				else
					dm_d = RAFD_AM_GBR;
			end
			default: ill_d = 1'b1; // RULE_26
		endcase
	end

	always_comb
	begin
		case (sz_d)
			RAFD_SZ_W: step = SZ_WORD;
			RAFD_SZ_L: step = SZ_LONG;
			default:   step = SZ_BYTE;
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// issue handshake; a waited bus holds dec_valid_q and drops insn_ready a cycle later
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			state_q <= RAFD_ST_IDLE;
		else
			case (state_q)
				RAFD_ST_IDLE:  state_q <= take ? RAFD_ST_ISSUE : RAFD_ST_IDLE;
				RAFD_ST_ISSUE: state_q <= bus_wait ? RAFD_ST_HOLD
				                          : (take ? RAFD_ST_ISSUE : RAFD_ST_IDLE);
				RAFD_ST_HOLD:  state_q <= bus_wait ? RAFD_ST_HOLD : RAFD_ST_IDLE; // RULE_22
				default:       state_q <= RAFD_ST_IDLE;
			endcase
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			insn_ready <= 1'b0;
		else
			insn_ready <= !bus_wait;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			dec_valid_q <= 1'b0;
		else if (!bus_wait)
			dec_valid_q <= take;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			fetch_pc_q <= 32'h0000_0000;
		else if (take)
			fetch_pc_q <= fetch_pc_q + PC_STEP; // RULE_23
	end

	////////////////////////////////////////////////////////////////////////
	// fields, address and writebacks
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			src_mode_q <= RAFD_AM_NONE;
			dst_mode_q <= RAFD_AM_NONE;
			op_class_q <= RAFD_OP_OTHER;
			size_q     <= RAFD_SZ_B;
			src_reg_q  <= REG_ZERO;
			dst_reg_q  <= REG_ZERO;
			imm_q      <= 32'h0000_0000;
			illegal_q  <= 1'b0;
			mem_access_q <= 1'b0;
		end
		else if (take)
		begin
			src_mode_q <= sm_d;
			dst_mode_q <= dm_d;
			op_class_q <= ill_d ? RAFD_OP_ILL : op_d;
			size_q     <= sz_d;
			src_reg_q  <= (f_hi == 4'h4 && op_d == RAFD_OP_BRA) ? f_n
			              : (f_hi == 4'h8 && !f_n[2]) ? REG_ZERO : f_m; // RULE_10
			dst_reg_q  <= (f_hi == 4'h8 && f_n[2]) || f_hi == 4'hC ? REG_ZERO : f_n;
			imm_q      <= imm_ext;
			illegal_q  <= ill_d; // RULE_26
			mem_access_q <= !ill_d && (sm_d inside {RAFD_AM_IND, RAFD_AM_POST, RAFD_AM_PRE,
			                RAFD_AM_DISP, RAFD_AM_IDX, RAFD_AM_GBR}
			                || dm_d inside {RAFD_AM_IND, RAFD_AM_POST, RAFD_AM_PRE,
			                RAFD_AM_DISP, RAFD_AM_IDX, RAFD_AM_GBR}
			                || (sm_d == RAFD_AM_PCD && op_d == RAFD_OP_OTHER && f_hi != 4'hC));
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			ea_q <= 32'h0000_0000;
		else if (take)
		begin
			if (sm_d == RAFD_AM_PRE || dm_d == RAFD_AM_PRE)
				ea_q <= dst_value - step; // RULE_03
			else if (sm_d == RAFD_AM_DISP && f_hi == 4'h8)
				ea_q <= src_value + disp_ext; // RULE_09
			else if (sm_d == RAFD_AM_DISP)
				ea_q <= src_value + disp_ext; // RULE_11
			else if (dm_d == RAFD_AM_DISP)
				ea_q <= (f_hi == 4'h8 ? src_value : dst_value) + disp_ext; // RULE_10
			else if (sm_d == RAFD_AM_GBR || dm_d == RAFD_AM_GBR)
				ea_q <= gbr_value + (f_n[3] ? r0_value : disp_ext); // RULE_12
			else if (sm_d == RAFD_AM_IDX || dm_d == RAFD_AM_IDX)
				ea_q <= r0_value + (sm_d == RAFD_AM_IDX ? src_value : dst_value);
			else if (sm_d == RAFD_AM_PCD)
				ea_q <= pc_value + disp_ext; // RULE_13
			else if (sm_d == RAFD_AM_POST || sm_d == RAFD_AM_IND)
				ea_q <= src_value; // RULE_02
			else
				ea_q <= dst_value; // RULE_01
		end
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			wb_en_q  <= 1'b0;
			wb_reg_q <= REG_ZERO;
			wb_val_q <= 32'h0000_0000;
			wb2_en_q <= 1'b0;
			wb2_reg_q <= REG_ZERO;
			wb2_val_q <= 32'h0000_0000;
		end
		else if (take)
		begin
			wb_en_q  <= !ill_d && (sm_d == RAFD_AM_POST || dm_d == RAFD_AM_PRE);
			wb_reg_q <= (sm_d == RAFD_AM_POST) ? f_m : f_n;
			wb_val_q <= (sm_d == RAFD_AM_POST) ? src_value + step : dst_value - step; // RULE_02
			wb2_en_q <= !ill_d && op_d == RAFD_OP_MAC; // RULE_08
			wb2_reg_q <= f_n;
			wb2_val_q <= dst_value + step;
		end
		else
		begin
			wb_en_q  <= 1'b0;
			wb2_en_q <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// branch resolution and functional results
	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			branch_q     <= 1'b0;
			delay_slot_q <= 1'b0;
			target_q     <= 32'h0000_0000;
		end
		else if (take)
		begin
			case (op_d)
				RAFD_OP_BF:  branch_q <= !ill_d && !cond_flag; // RULE_16
				RAFD_OP_BT:  branch_q <= !ill_d && cond_flag;
				RAFD_OP_BRA: branch_q <= !ill_d;
				default:     branch_q <= 1'b0;
			endcase
			delay_slot_q <= dslot_d; // RULE_24
			// the register-relative form names its register in bits 11:8
			target_q <= (sm_d == RAFD_AM_PCR) ? pc_value + dst_value
			            : pc_value + disp_ext; // RULE_04
		end
		else
			branch_q <= 1'b0;
	end

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
		begin
			flag_we_q  <= 1'b0;
			flag_val_q <= 1'b0;
			alu_res_q  <= 32'h0000_0000;
			qbit_q     <= 1'b0;
			mbit_q     <= 1'b0;
			tas_byte_q <= 8'h00;
		end
		else if (take)
		begin
			flag_we_q <= !ill_d && op_d inside {RAFD_OP_TST, RAFD_OP_TAS,
			             RAFD_OP_DIVS, RAFD_OP_ROTATE_LEFT_THROUGH_T};
			tas_byte_q <= mem_byte | TAS_MSB; // RULE_17
			case (op_d)
				RAFD_OP_TST:
				begin
					alu_res_q  <= dst_value;
					flag_val_q <= ((f_hi == 4'hC ? r0_value : dst_value)
					              & (sm_d == RAFD_AM_IMM ? imm_ext : src_value)) == 32'h0; // RULE_18
				end
				RAFD_OP_TAS:
				begin
					alu_res_q  <= dst_value;
					flag_val_q <= (mem_byte == 8'h00); // RULE_17
				end
				RAFD_OP_XTR:
				begin
					alu_res_q  <= {src_value[15:0], dst_value[31:16]}; // RULE_19
					flag_val_q <= cond_flag;
				end
				RAFD_OP_DIVS:
				begin
					qbit_q     <= dst_value[XLEN-1]; // RULE_20
					mbit_q     <= src_value[XLEN-1];
					flag_val_q <= dst_value[XLEN-1] ^ src_value[XLEN-1];
					alu_res_q  <= dst_value;
				end
				RAFD_OP_ROTATE_LEFT_THROUGH_T:
				begin
					alu_res_q  <= {dst_value[30:0], cond_flag}; // RULE_21
					flag_val_q <= dst_value[XLEN-1];
				end
				default:
				begin
					alu_res_q  <= imm_ext;
					flag_val_q <= cond_flag;
				end
			endcase
		end
		else
			flag_we_q <= 1'b0;
	end

	////////////////////////////////////////////////////////////////////////
	a_post_inc_wb: assert property (@(posedge core_clk) disable iff (!nrst)
		take && sm_d == RAFD_AM_POST && !ill_d |=> wb_en_q && wb_val_q == ea_q + step_q)
		else $error("post-increment writeback wrong"); // RULE_02
	a_pre_dec_ea: assert property (@(posedge core_clk) disable iff (!nrst)
		take && dm_d == RAFD_AM_PRE && !ill_d |=> wb_en_q && wb_val_q == ea_q)
		else $error("pre-decrement address differs from writeback"); // RULE_03
	a_bf_cond: assert property (@(posedge core_clk) disable iff (!nrst)
		take && op_d == RAFD_OP_BF && !ill_d |=> branch_q == !$past(cond_flag))
		else $error("false branch decision wrong"); // RULE_16
	a_bt_cond: assert property (@(posedge core_clk) disable iff (!nrst)
		take && op_d == RAFD_OP_BT && !ill_d |=> branch_q == $past(cond_flag))
		else $error("true branch decision wrong"); // RULE_16
	a_trap_vec: assert property (@(posedge core_clk) disable iff (!nrst)
		take && op_d == RAFD_OP_TRAP |=> imm_q[1:0] == 2'h0 && imm_q[9:2] == $past(insn_word[7:0]))
		else $error("trap vector offset wrong"); // RULE_07
	a_rotate_left_through_t_res: assert property (@(posedge core_clk) disable iff (!nrst)
		take && op_d == RAFD_OP_ROTATE_LEFT_THROUGH_T && !ill_d |=> alu_res_q[0] == $past(cond_flag)
		&& flag_val_q == $past(dst_value[31]))
		else $error("rotate through flag wrong"); // RULE_21
	a_tas_msb: assert property (@(posedge core_clk) disable iff (!nrst)
		take && op_d == RAFD_OP_TAS |=> tas_byte_q[7] && flag_val_q == ($past(mem_byte) == 8'h00))
		else $error("test-and-set result wrong"); // RULE_17
	a_pc_step: assert property (@(posedge core_clk) disable iff (!nrst)
		take |=> fetch_pc_q == $past(fetch_pc_q) + PC_STEP)
		else $error("fetch pointer not advanced by one word"); // RULE_23
	a_wait_hold: assert property (@(posedge core_clk) disable iff (!nrst)
		bus_wait |=> !insn_ready)
		else $error("decode accepted during wait state"); // RULE_22
	a_ill_flag: assert property (@(posedge core_clk) disable iff (!nrst)
		take && f_hi == 4'hF |=> illegal_q && !branch_q)
		else $error("undefined opcode not flagged"); // RULE_26

	always_ff @(posedge core_clk)
	begin
		if (!nrst)
			step_q <= SZ_BYTE;
		else if (take)
			step_q <= step;
	end

	c_mac: cover property (@(posedge core_clk) take && op_d == RAFD_OP_MAC);
	c_branch: cover property (@(posedge core_clk) branch_q && delay_slot_q);
	c_wait: cover property (@(posedge core_clk) state_q == RAFD_ST_HOLD);
	c_pre: cover property (@(posedge core_clk) take && dm_d == RAFD_AM_PRE);
endmodule
`default_nettype wire

// ===== verification/rafd_fetch_model.sv
// fetch side and register file model feeding the decoder
`timescale 1ns/10ps
`default_nettype none
module rafd_fetch_model
	import rafd_pkg::*;
(
	input  wire logic        insn_valid,
	input  wire logic [15:0] insn_word,
	output logic      [31:0] pc_value,
	output logic      [31:0] gbr_value,
	output logic      [31:0] src_value,
	output logic      [31:0] dst_value,
	output logic      [31:0] r0_value
);
	function automatic logic [31:0] reg_val(input logic [3:0] n);
		reg_val = (n == 4'hF) ? 32'h8000_0001 : (32'h0000_0100 << n);
	endfunction

	// reads belong to the offered word only; inverted otherwise so late sampling shows
	always_comb
	begin
		pc_value  = 32'h0000_2000;
		gbr_value = 32'h0000_3000;
		src_value = reg_val(insn_word[7:4]);
		dst_value = reg_val(insn_word[11:8]);
		r0_value  = reg_val(4'h0);
		if (!insn_valid)
		begin
			pc_value  = ~pc_value;
			gbr_value = ~gbr_value;
			src_value = ~src_value;
			dst_value = ~dst_value;
			r0_value  = ~r0_value;
		end
	end
endmodule
`default_nettype wire

// ===== verification/rafd_decoder_tb.sv
// self-checking bench for the addressing format decoder
`timescale 1ns/10ps
`default_nettype none
module rafd_decoder_tb
	import rafd_pkg::*;
;
	localparam logic [31:0] PCV = 32'h0000_2000;
	localparam logic [31:0] GBV = 32'h0000_3000;
	logic        core_clk, nrst, insn_valid, cond_flag, bus_wait;
	logic [15:0] insn_word;
	logic [7:0]  mem_byte, tas_byte_q;
	logic [31:0] pc_v, gbr_v, src_v, dst_v, r0_v, imm_q, ea_q, wb_val_q, wb2_val_q;
	logic [31:0] target_q, alu_res_q, fetch_pc_q;
	logic [3:0]  wb_reg_q, wb2_reg_q, src_reg_q;
	logic        delay_slot_q;
	logic        insn_ready, dec_valid_q, wb_en_q, wb2_en_q, mem_access_q, branch_q;
	logic        flag_we_q, flag_val_q, qbit_q, mbit_q, illegal_q;
	rafd_mode_t  src_mode_q;
	rafd_op_t    op_class_q;
	int          mismatches;
	int          num_checks;

	rafd_fetch_model u_rafd_fetch_model (.insn_valid(insn_valid), .insn_word(insn_word),
		.pc_value(pc_v), .gbr_value(gbr_v), .src_value(src_v), .dst_value(dst_v),
		.r0_value(r0_v));

	rafd_decoder u_rafd_decoder (.core_clk(core_clk), .nrst(nrst), .insn_valid(insn_valid),
		.insn_word(insn_word), .pc_value(pc_v), .gbr_value(gbr_v), .src_value(src_v),
		.dst_value(dst_v), .r0_value(r0_v), .cond_flag(cond_flag), .mem_byte(mem_byte),
		.bus_wait(bus_wait), .insn_ready(insn_ready), .dec_valid_q(dec_valid_q),
		.src_mode_q(src_mode_q), .dst_mode_q(), .op_class_q(op_class_q), .size_q(),
		.src_reg_q(src_reg_q), .dst_reg_q(), .imm_q(imm_q), .ea_q(ea_q),
		.wb_en_q(wb_en_q), .wb_reg_q(wb_reg_q),
		.wb_val_q(wb_val_q), .wb2_en_q(wb2_en_q), .wb2_reg_q(wb2_reg_q),
		.wb2_val_q(wb2_val_q), .mem_access_q(mem_access_q), .branch_q(branch_q),
		.delay_slot_q(delay_slot_q), .target_q(target_q), .flag_we_q(flag_we_q),
		.flag_val_q(flag_val_q), .alu_res_q(alu_res_q), .qbit_q(qbit_q), .mbit_q(mbit_q),
		.tas_byte_q(tas_byte_q), .illegal_q(illegal_q), .fetch_pc_q(fetch_pc_q));

	function automatic logic [31:0] rv(input logic [3:0] n);
		rv = (n == 4'hF) ? 32'h8000_0001 : (32'h0000_0100 << n);
	endfunction

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("unexpected value at %0t: got %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		if (mismatches == 0 && num_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic stall();
		mismatches++;
		$display("unexpected stall at %0t", $time);
		results();
	endtask

	// offer one word, wait for the take, then for the answer; the idle gap drops dec_valid_q
	task automatic run(input logic [15:0] w, input logic cf, input logic [7:0] mb);
		int n;
		n = 0;
		@(posedge core_clk);
		insn_valid <= 1'b1;
		insn_word  <= w;
		cond_flag  <= cf;
		mem_byte   <= mb;
		@(negedge core_clk);
		while (insn_ready !== 1'b1)
		begin
			n++;
			if (n > 50)
				stall();
			@(negedge core_clk);
		end
		@(posedge core_clk);
		insn_valid <= 1'b0;
		@(negedge core_clk);
		while (dec_valid_q !== 1'b1)
		begin
			n++;
			if (n > 55)
				stall();
			@(negedge core_clk);
		end
	endtask

	task automatic t_addr();
		run(16'h6123, 1'b0, 8'h00);
		chk(32'(src_mode_q), 32'(RAFD_AM_REG));
		chk(32'(mem_access_q), 32'h0);
		chk(32'(illegal_q), 32'h0);
		run(16'h6122, 1'b0, 8'h00);
		chk(32'(src_mode_q), 32'(RAFD_AM_IND));
		chk(ea_q, rv(4'h2));
		for (int s = 0; s < 3; s++)
		begin
			run(16'h6124 + 16'(s), 1'b0, 8'h00);
			chk(ea_q, rv(4'h2));
			chk(32'({wb_en_q, wb_reg_q}), 32'h12);
			chk(wb_val_q, rv(4'h2) + (32'h1 << s));
			run(16'h2124 + 16'(s), 1'b0, 8'h00);
			chk(ea_q, rv(4'h1) - (32'h1 << s));
			chk(32'({wb_en_q, wb_reg_q}), 32'h11);
			chk(wb_val_q, rv(4'h1) - (32'h1 << s));
		end
		run(16'h4123, 1'b0, 8'h00);
		chk(target_q, PCV + rv(4'h1));
		chk(32'({branch_q, delay_slot_q, src_reg_q}), 32'h31);
		run(16'h412F, 1'b0, 8'h00);
		chk(32'({wb2_en_q, wb2_reg_q}), 32'h11);
		chk(wb2_val_q, rv(4'h1) + 32'h2);
	endtask

	task automatic t_imm();
		run(16'hE180, 1'b0, 8'h00);
		chk(imm_q, 32'hFFFF_FF80);
		run(16'h8880, 1'b0, 8'h00);
		chk(imm_q, 32'hFFFF_FF80);
		run(16'h7F7F, 1'b0, 8'h00);
		chk(imm_q, 32'h0000_007F);
		for (int k = 0; k < 4; k++)
		begin
			run({8'hC8 + 8'(k), 8'h80}, 1'b0, 8'h00);
			chk(imm_q, 32'h0000_0080);
		end
		run(16'hC3FF, 1'b0, 8'h00);
		chk(imm_q, 32'h0000_03FC);
	endtask

	task automatic t_disp();
		run(16'h8525, 1'b0, 8'h00);
		chk(ea_q, rv(4'h2) + 32'hA);
		run(16'h8125, 1'b0, 8'h00);
		chk(ea_q, rv(4'h2) + 32'hA);
		chk(32'(src_reg_q), 32'h0);
		run(16'h5123, 1'b0, 8'h00);
		chk(ea_q, rv(4'h2) + 32'hC);
		run(16'h1123, 1'b0, 8'h00);
		chk(ea_q, rv(4'h1) + 32'hC);
		run(16'hC605, 1'b0, 8'h00);
		chk(ea_q, GBV + 32'h14);
		run(16'hC405, 1'b0, 8'h00);
		chk(ea_q, GBV + 32'h5);
		run(16'h9105, 1'b0, 8'h00);
		chk(ea_q, PCV + 32'hA);
	endtask

	task automatic t_flow();
		logic [31:0] p;
		run(16'h8BFE, 1'b0, 8'h00);
		chk(32'({branch_q, delay_slot_q}), 32'h2);
		chk(target_q, PCV - 32'h4);
		run(16'h8BFE, 1'b1, 8'h00);
		chk(32'(branch_q), 32'h0);
		run(16'h8902, 1'b1, 8'h00);
		chk(32'(branch_q), 32'h1);
		chk(target_q, PCV + 32'h4);
		run(16'h8902, 1'b0, 8'h00);
		chk(32'(branch_q), 32'h0);
		run(16'hAFFB, 1'b0, 8'h00);
		chk(target_q, PCV - 32'hA);
		chk(32'({branch_q, delay_slot_q}), 32'h3);
		run(16'hFFFF, 1'b0, 8'h00);
		chk(32'(illegal_q), 32'h1);
		chk(32'(op_class_q), 32'(RAFD_OP_ILL));
		p = fetch_pc_q;
		run(16'h0009, 1'b0, 8'h00);
		chk(fetch_pc_q, p + 32'h2);
		@(posedge core_clk);
		bus_wait <= 1'b1;
		repeat (3) @(negedge core_clk);
		chk(32'(insn_ready), 32'h0);
		@(posedge core_clk);
		bus_wait <= 1'b0;
	endtask

	task automatic t_alu();
		run(16'h411B, 1'b0, 8'h00);
		chk({flag_we_q, flag_val_q, tas_byte_q}, {2'b11, 8'h80});
		run(16'h411B, 1'b0, 8'h05);
		chk({flag_val_q, tas_byte_q}, {1'b0, 8'h85});
		run(16'h2128, 1'b0, 8'h00);
		chk({flag_we_q, flag_val_q}, 2'b11);
		run(16'h2118, 1'b1, 8'h00);
		chk(32'(flag_val_q), 32'h0);
		run(16'h212D, 1'b0, 8'h00);
		chk(alu_res_q, 32'h0400_0000);
		run(16'h2F17, 1'b0, 8'h00);
		chk({qbit_q, mbit_q, flag_val_q}, 3'b101);
		run(16'h4F24, 1'b1, 8'h00);
		chk(32'(flag_val_q), 32'h1);
		chk(alu_res_q, 32'h0000_0003);
	endtask

	initial
	begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial
	begin
		nrst       = 1'b0;
		insn_valid = 1'b0;
		insn_word  = 16'h0009;
		cond_flag  = 1'b0;
		mem_byte   = 8'h00;
		bus_wait   = 1'b0;
		mismatches = 0;
		num_checks = 0;
		repeat (16) @(posedge core_clk);
		nrst <= 1'b1;
		t_addr();
		t_imm();
		t_disp();
		t_flow();
		t_alu();
		results();
	end
endmodule
`default_nettype wire
